// ---- src/cosg_regs.svh ----
// Object dictionary indexes, sub-indexes, field layouts, reset values and timing counts
`ifndef COSG_REGS_SVH
`define COSG_REGS_SVH
// ----------------------------------------------------------------------------
// Object indexes
// ----------------------------------------------------------------------------
`define COSG_IDX_SYNC_WINDOW   16'h1007
`define COSG_IDX_DEV_NAME      16'h1008
`define COSG_IDX_HW_VER        16'h1009
`define COSG_IDX_SW_VER        16'h100A
`define COSG_IDX_GUARD_TIME    16'h100C
`define COSG_IDX_LIFE_FACTOR   16'h100D
`define COSG_IDX_STORE         16'h1010
`define COSG_IDX_RESTORE       16'h1011
// ----------------------------------------------------------------------------
// Sub-indexes and fixed values
// ----------------------------------------------------------------------------
`define COSG_SUB_HIGHEST       8'h00
`define COSG_SUB_ALL           8'h01
`define COSG_SUB_COMM          8'h02
`define COSG_SUB_APP           8'h03
`define COSG_HIGHEST_RESET     8'h03
`define COSG_GUARD_RESET       16'h0000
`define COSG_LIFE_RESET        8'h00
`define COSG_WINDOW_RESET      32'h0000_0000
`define COSG_KEY_SAVE          32'h6576_6173
`define COSG_KEY_LOAD          32'h6461_6F6C
`define COSG_STORE_READBACK    32'h0000_0001
// ----------------------------------------------------------------------------
// Abort codes and emergency fields
// ----------------------------------------------------------------------------
`define COSG_ABORT_BAD_VALUE   32'h0800_0020
`define COSG_ABORT_NO_OBJECT   32'h0602_0000
`define COSG_ABORT_READ_ONLY   32'h0601_0002
`define COSG_EMCY_SYNC_CODE    16'h8240
`define COSG_EMCY_INT_CODE     16'h0001
`define COSG_EMCY_ERR_REG      8'h10
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define COSG_CLK_HZ            40000000
`define COSG_US_NS             1000
`define COSG_MS_US             1000
`define COSG_CLK_NS            25
`define COSG_US_CYCLES         (`COSG_US_NS / `COSG_CLK_NS)
`define COSG_STR_LEN           8
`endif

// ---- src/cosg_pkg.sv ----
// Types shared by the communication-object block
`default_nettype none
package cosg_pkg;
  typedef enum logic [1:0] {
    COSG_WIN_IDLE  = 2'b00,
    COSG_WIN_OPEN  = 2'b01,
    COSG_WIN_DROP  = 2'b11
  } cosg_win_type;
  typedef enum logic [1:0] {
    COSG_REACT_NONE  = 2'b00,
    COSG_REACT_FAULT = 2'b01,
    COSG_REACT_STOP  = 2'b10,
    COSG_REACT_QUICK = 2'b11
  } cosg_react_type;
endpackage : cosg_pkg
`default_nettype wire

// ---- src/cosg_tick_gen.sv ----
// Microsecond and millisecond tick generator
`timescale 1ns/10ps
`default_nettype none
`include "cosg_regs.svh"
module cosg_tick_gen
  import cosg_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  output logic      us_tick,
  output logic      ms_tick
);
  localparam logic [5:0] US_LAST = 6'(`COSG_US_CYCLES - 1);
  localparam logic [9:0] MS_LAST = 10'(`COSG_MS_US - 1);
  logic [5:0] us_cnt;
  logic [9:0] ms_cnt;
  logic [5:0] next_us_cnt;
  logic [9:0] next_ms_cnt;
  logic       next_us_tick;
  logic       next_ms_tick;

  // Cascaded dividers; ms ticks line up with us ticks
  always_comb begin
    next_us_tick = (us_cnt == US_LAST);
    next_us_cnt  = next_us_tick ? 6'h00 : us_cnt + 6'h01;
    next_ms_tick = next_us_tick && (ms_cnt == MS_LAST);
    next_ms_cnt  = ms_cnt;
    if (next_us_tick) begin
      next_ms_cnt = next_ms_tick ? 10'h000 : ms_cnt + 10'h001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      us_cnt  <= 6'h00;
      ms_cnt  <= 10'h000;
      us_tick <= 1'b0;
      ms_tick <= 1'b0;
    end else begin
      us_cnt  <= next_us_cnt;
      ms_cnt  <= next_ms_cnt;
      us_tick <= next_us_tick;
      ms_tick <= next_ms_tick;
    end
  end
endmodule : cosg_tick_gen
`default_nettype wire

// ---- src/cosg_core.sv ----
// Sync window monitor, node guarding, store/restore and identity strings
`timescale 1ns/10ps
`default_nettype none
`include "cosg_regs.svh"
// ----------------------------------------------------------------------------
// Communication-object core
// ----------------------------------------------------------------------------
// Behaviour
// - Receive update and sync transmit must finish inside the window after SYNC
// - Window overrun sends emergency and drops sync PDOs until next SYNC
// - Window length counts microseconds
// - Window length zero at SYNC disables monitoring; zero written during an open window overruns at the next microsecond tick
// - Emergency once; re-armed by a clean period, then a new violation
// - Name, hardware and software version strings, read-only, segmented upload
// - Guard time 16-bit read/write, reset zero, millisecond units
// - Guarding timeout equals guard time times lifetime factor
// - Guarding disabled when guard time or lifetime factor is zero
// - Guarding timeout triggers the selected connection-loss reaction
// - Store object has sub-indexes 1..3, sub-index 0 reads 3
// - Keyword save on store sub-index 3 saves application parameters
// - Other store values abort and nothing is stored
// - Restore object has three sub-indexes; only sub-index 3 returns defaults, 1 and 2 restore nothing
// - Keyword load on restore sub-index 3 reloads application defaults
// - Other restore values abort and nothing is restored
// - Emergency: code bytes 0-1, error register 2, zeros 3-5, internal 6-7
module cosg_core
  import cosg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       sync_rx,
  input  wire logic       rx_update_done,
  input  wire logic       tx_pdo_done,
  input  wire logic       guard_req,
  input  wire logic [1:0] conn_loss_action,
  input  wire logic       sdo_req,
  input  wire logic       sdo_write,
  input  wire logic       sdo_segment,
  input  wire logic [15:0] sdo_index,
  input  wire logic [7:0] sdo_subindex,
  input  wire logic [31:0] sdo_wdata,
  output logic            sdo_ack,
  output logic            sdo_abort,
  output logic [31:0]     sdo_rdata,
  output logic [31:0]     sdo_abort_code,
  output logic [3:0]      sdo_seg_len,
  output logic            sdo_seg_last,
  output logic            pdo_drop,
  output logic            emcy_tx,
  output logic [63:0]     emcy_data,
  output logic            guard_expired,
  output logic [1:0]      conn_loss_react,
  output logic            save_app_params,
  output logic            load_app_defaults,
  output logic [31:0]     sync_window_length,
  output logic [15:0]     guarding_interval_ms,
  output logic [7:0]      guarding_multiplier
);
  localparam logic [63:0] DEVICE_NAME_STR = 64'h4452_4956_4530_3031; // Arbitrary string
  localparam logic [63:0] HW_VERSION_STR  = 64'h4857_2D52_4556_3031; // Arbitrary string
  localparam logic [63:0] SW_VERSION_STR  = 64'h3030_2E30_312E_3030; // Arbitrary string
  logic us_tick, ms_tick;
  // ----------------------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------------------
  cosg_tick_gen u_tick (
    .clk     (clk),
    .nrst    (nrst),
    .us_tick (us_tick),
    .ms_tick (ms_tick)
  );
  // Pick a string by object index
  function automatic logic [63:0] pick_string(input logic [15:0] idx);
    case (idx)
      `COSG_IDX_DEV_NAME: pick_string = DEVICE_NAME_STR;
      `COSG_IDX_HW_VER:   pick_string = HW_VERSION_STR;
      default:            pick_string = SW_VERSION_STR;
    endcase
  endfunction : pick_string
  // ----------------------------------------------------------------------------
  // Sync window monitor
  // ----------------------------------------------------------------------------
  cosg_win_type win_state, next_win_state;
  logic [31:0]  win_cnt, next_win_cnt;
  logic         rx_done, next_rx_done;
  logic         tx_done, next_tx_done;
  logic         emcy_armed, next_emcy_armed;
  logic         next_emcy_tx, next_pdo_drop;
  logic         win_done_now;
  // Done flags latch so both steps may finish in any order
  assign win_done_now = (rx_done | rx_update_done) & (tx_done | tx_pdo_done);
  always_comb begin
    next_win_state  = win_state;
    next_win_cnt    = win_cnt;
    next_rx_done    = rx_done | rx_update_done;
    next_tx_done    = tx_done | tx_pdo_done;
    next_emcy_armed = emcy_armed;
    next_emcy_tx    = 1'b0;
    next_pdo_drop   = pdo_drop;
    case (win_state)
      COSG_WIN_IDLE: begin
        next_pdo_drop = 1'b0;
      end
      COSG_WIN_OPEN: begin
        if (win_done_now) begin
          next_win_state  = COSG_WIN_IDLE;
          next_emcy_armed = 1'b1;
        end else if (us_tick) begin
          if (win_cnt + 32'h1 >= sync_window_length) begin
            next_win_state = COSG_WIN_DROP;
            next_pdo_drop  = 1'b1;
            next_emcy_tx   = emcy_armed;
            next_emcy_armed = 1'b0;
          end else begin
            next_win_cnt = win_cnt + 32'h1;
          end
        end
      end
      COSG_WIN_DROP: begin
        next_pdo_drop = 1'b1;
      end
      default: begin
        next_win_state = COSG_WIN_IDLE;
      end
    endcase
    // A fresh SYNC restarts the window whatever the state
    if (sync_rx) begin
      next_win_cnt  = 32'h0;
      next_rx_done  = 1'b0;
      next_tx_done  = 1'b0;
      next_pdo_drop = 1'b0;
      next_win_state = (sync_window_length == 32'h0) ? COSG_WIN_IDLE : COSG_WIN_OPEN;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      win_state  <= COSG_WIN_IDLE;
      win_cnt    <= 32'h0;
      rx_done    <= 1'b0;
      tx_done    <= 1'b0;
      emcy_armed <= 1'b1;
      emcy_tx    <= 1'b0;
      pdo_drop   <= 1'b0;
    end else begin
      win_state  <= next_win_state;
      win_cnt    <= next_win_cnt;
      rx_done    <= next_rx_done;
      tx_done    <= next_tx_done;
      emcy_armed <= next_emcy_armed;
      emcy_tx    <= next_emcy_tx;
      pdo_drop   <= next_pdo_drop;
    end
  end
  // Emergency payload is constant for this single event source
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      emcy_data <= 64'h0;
    end else begin
      emcy_data <= {`COSG_EMCY_INT_CODE, 24'h0, `COSG_EMCY_ERR_REG, `COSG_EMCY_SYNC_CODE};
    end
  end
  // ----------------------------------------------------------------------------
  // Node guarding
  // ----------------------------------------------------------------------------
  logic [23:0] guard_cnt, next_guard_cnt;
  logic        next_guard_expired, guard_on;
  logic [1:0]  next_conn_loss_react;
  logic [23:0] guard_limit;
  assign guard_limit = 24'(guarding_interval_ms) * 24'(guarding_multiplier);
  assign guard_on    = (guarding_interval_ms != 16'h0) && (guarding_multiplier != 8'h0);
  // Expiry is a one-cycle pulse; counter then holds until the next request
  always_comb begin
    next_guard_cnt       = guard_cnt;
    next_guard_expired   = 1'b0;
    next_conn_loss_react = conn_loss_react;
    if (!guard_on) begin
      next_guard_cnt = 24'h0;
    end else if (guard_req) begin
      next_guard_cnt = 24'h0;
    end else if (ms_tick && guard_cnt < guard_limit) begin
      next_guard_cnt = guard_cnt + 24'h1;
      if (guard_cnt + 24'h1 == guard_limit) begin
        next_guard_expired   = 1'b1;
        next_conn_loss_react = conn_loss_action;
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      guard_cnt       <= 24'h0;
      guard_expired   <= 1'b0;
      conn_loss_react <= 2'b00;
    end else begin
      guard_cnt       <= next_guard_cnt;
      guard_expired   <= next_guard_expired;
      conn_loss_react <= next_conn_loss_react;
    end
  end
  // ----------------------------------------------------------------------------
  // SDO object access
  // ----------------------------------------------------------------------------
  logic [31:0] next_sync_window_length, next_sdo_rdata, next_sdo_abort_code, cmd_key;
  logic [15:0] next_guarding_interval_ms;
  logic [7:0]  next_guarding_multiplier;
  logic [3:0]  next_sdo_seg_len, seg_pos, next_seg_pos;
  logic [63:0] str_sel;
  logic        next_sdo_ack, next_sdo_abort, next_sdo_seg_last, next_save, next_load, is_string, is_cmd_obj;
  assign is_string  = (sdo_index == `COSG_IDX_DEV_NAME) || (sdo_index == `COSG_IDX_HW_VER) ||
                      (sdo_index == `COSG_IDX_SW_VER);
  assign is_cmd_obj = (sdo_index == `COSG_IDX_STORE) || (sdo_index == `COSG_IDX_RESTORE);
  assign cmd_key    = (sdo_index == `COSG_IDX_STORE) ? `COSG_KEY_SAVE : `COSG_KEY_LOAD;
  assign str_sel    = pick_string(sdo_index);
  // Decode one request per pulse; answer comes the next cycle
  always_comb begin
    next_sync_window_length   = sync_window_length;
    next_guarding_interval_ms = guarding_interval_ms;
    next_guarding_multiplier  = guarding_multiplier;
    next_sdo_ack        = 1'b0;
    next_sdo_abort      = 1'b0;
    next_sdo_rdata      = sdo_rdata;
    next_sdo_abort_code = sdo_abort_code;
    next_sdo_seg_len    = sdo_seg_len;
    next_sdo_seg_last   = sdo_seg_last;
    next_save           = 1'b0;
    next_load           = 1'b0;
    next_seg_pos        = seg_pos;
    if (sdo_req) begin
      next_sdo_ack = 1'b1;
      if (is_string) begin
        if (sdo_write) begin
          next_sdo_ack        = 1'b0;
          next_sdo_abort      = 1'b1;
          next_sdo_abort_code = `COSG_ABORT_READ_ONLY;
        end else if (!sdo_segment) begin
          // Initiate: report total length and rewind
          next_seg_pos      = 4'h0;
          next_sdo_rdata    = 32'(`COSG_STR_LEN);
          next_sdo_seg_len  = 4'h0;
          next_sdo_seg_last = 1'b0;
        end else begin
          // Up to four characters per segment, first character low
          next_sdo_rdata    = 32'(str_sel >> {seg_pos[2:0], 3'b000});
          next_sdo_seg_len  = 4'h4;
          next_sdo_seg_last = (seg_pos + 4'h4 >= 4'(`COSG_STR_LEN));
          next_seg_pos      = next_sdo_seg_last ? 4'h0 : seg_pos + 4'h4;
        end
      end else if (is_cmd_obj) begin
        if (sdo_subindex == `COSG_SUB_HIGHEST) begin
          if (sdo_write) begin
            next_sdo_ack        = 1'b0;
            next_sdo_abort      = 1'b1;
            next_sdo_abort_code = `COSG_ABORT_READ_ONLY;
          end else begin
            next_sdo_rdata = {24'h0, `COSG_HIGHEST_RESET};
          end
        end else if (sdo_subindex > `COSG_SUB_APP) begin
          next_sdo_ack        = 1'b0;
          next_sdo_abort      = 1'b1;
          next_sdo_abort_code = `COSG_ABORT_NO_OBJECT;
        end else if (!sdo_write) begin
          next_sdo_rdata = `COSG_STORE_READBACK;
        end else if (sdo_wdata != cmd_key) begin
          next_sdo_ack        = 1'b0;
          next_sdo_abort      = 1'b1;
          next_sdo_abort_code = `COSG_ABORT_BAD_VALUE;
        end else if (sdo_subindex == `COSG_SUB_APP) begin
          next_save = (sdo_index == `COSG_IDX_STORE);
          next_load = (sdo_index == `COSG_IDX_RESTORE);
        end
      end else begin
        case (sdo_index)
          `COSG_IDX_SYNC_WINDOW: begin
            if (sdo_write) next_sync_window_length = sdo_wdata;
            next_sdo_rdata = sync_window_length;
          end
          `COSG_IDX_GUARD_TIME: begin
            if (sdo_write) next_guarding_interval_ms = sdo_wdata[15:0];
            next_sdo_rdata = {16'h0, guarding_interval_ms};
          end
          `COSG_IDX_LIFE_FACTOR: begin
            if (sdo_write) next_guarding_multiplier = sdo_wdata[7:0];
            next_sdo_rdata = {24'h0, guarding_multiplier};
          end
          default: begin
            next_sdo_ack        = 1'b0;
            next_sdo_abort      = 1'b1;
            next_sdo_abort_code = `COSG_ABORT_NO_OBJECT;
          end
        endcase
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_window_length   <= `COSG_WINDOW_RESET;
      guarding_interval_ms <= `COSG_GUARD_RESET;
      guarding_multiplier  <= `COSG_LIFE_RESET;
      sdo_ack              <= 1'b0;
      sdo_abort            <= 1'b0;
      sdo_rdata            <= 32'h0;
      sdo_abort_code       <= 32'h0;
      sdo_seg_len          <= 4'h0;
      sdo_seg_last         <= 1'b0;
      save_app_params      <= 1'b0;
      load_app_defaults    <= 1'b0;
      seg_pos              <= 4'h0;
    end else begin
      sync_window_length   <= next_sync_window_length;
      guarding_interval_ms <= next_guarding_interval_ms;
      guarding_multiplier  <= next_guarding_multiplier;
      sdo_ack              <= next_sdo_ack;
      sdo_abort            <= next_sdo_abort;
      sdo_rdata            <= next_sdo_rdata;
      sdo_abort_code       <= next_sdo_abort_code;
      sdo_seg_len          <= next_sdo_seg_len;
      sdo_seg_last         <= next_sdo_seg_last;
      save_app_params      <= next_save;
      load_app_defaults    <= next_load;
      seg_pos              <= next_seg_pos;
    end
  end
  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  AST_ZERO_WINDOW_QUIET: assert property (@(posedge clk) disable iff (!nrst)
    (sync_window_length == 32'h0) && $past(sync_window_length == 32'h0) |-> !emcy_tx)
    else $error("Emergency with window disabled");
  AST_EMCY_DROPS: assert property (@(posedge clk) disable iff (!nrst)
    emcy_tx |-> pdo_drop)
    else $error("Emergency without PDO drop");
  AST_EMCY_ONCE: assert property (@(posedge clk) disable iff (!nrst)
    emcy_tx |=> !emcy_tx ##0 !emcy_armed)
    else $error("Emergency not one-shot");
  AST_DROP_UNTIL_SYNC: assert property (@(posedge clk) disable iff (!nrst)
    pdo_drop && !sync_rx |=> pdo_drop)
    else $error("Drop released without SYNC");
  AST_SYNC_RESTART: assert property (@(posedge clk) disable iff (!nrst)
    sync_rx |=> win_cnt == 32'h0)
    else $error("Window timer not restarted");
  AST_EMCY_FORMAT: assert property (@(posedge clk) disable iff (!nrst)
    emcy_tx |-> emcy_data == 64'h0001_0000_0010_8240)
    else $error("Emergency layout wrong");
  AST_GUARD_OFF: assert property (@(posedge clk) disable iff (!nrst)
    (guarding_interval_ms == 16'h0 || guarding_multiplier == 8'h0) |=> !guard_expired)
    else $error("Guard fired while disabled");
  AST_GUARD_REACT: assert property (@(posedge clk) disable iff (!nrst)
    guard_expired |-> conn_loss_react == $past(conn_loss_action))
    else $error("Wrong connection-loss reaction");
  AST_BAD_STORE: assert property (@(posedge clk) disable iff (!nrst)
    sdo_req && sdo_write && sdo_index == 16'h1010 && sdo_subindex == 8'h03 && sdo_wdata != 32'h6576_6173
    |=> sdo_abort && !save_app_params)
    else $error("Bad store keyword accepted");
  AST_GOOD_LOAD: assert property (@(posedge clk) disable iff (!nrst)
    sdo_req && sdo_write && sdo_index == 16'h1011 && sdo_subindex == 8'h03 && sdo_wdata == 32'h6461_6F6C
    |=> load_app_defaults && sdo_ack)
    else $error("Load keyword not honoured");
  AST_HIGHEST_SUB: assert property (@(posedge clk) disable iff (!nrst)
    sdo_req && !sdo_write && sdo_index == 16'h1010 && sdo_subindex == 8'h00 |=> sdo_rdata == 32'h3)
    else $error("Highest sub-index wrong");
  COVER_EMCY: cover property (@(posedge clk) disable iff (!nrst) emcy_tx);
  COVER_SAVE: cover property (@(posedge clk) disable iff (!nrst) save_app_params);
  COVER_GUARD: cover property (@(posedge clk) disable iff (!nrst) guard_expired);
  COVER_SEG_LAST: cover property (@(posedge clk) disable iff (!nrst) sdo_ack && sdo_seg_last);
endmodule : cosg_core
`default_nettype wire

// ---- testbench/cosg_master_model.sv ----
// Master-side model: SYNC source and PDO completion timing
`timescale 1ns/10ps
`default_nettype none
module cosg_master_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        go,
  input  wire logic [15:0] lag,
  output logic             sync_rx,
  output logic             rx_update_done,
  output logic             tx_pdo_done
);
  logic [15:0] cnt;
  // ------------
  // SYNC on go, receive done lag cycles later, transmit done one cycle after that
  // ------------
  // Lag zero never finishes, so the window must run out
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt            <= 16'h0000;
      sync_rx        <= 1'b0;
      rx_update_done <= 1'b0;
      tx_pdo_done    <= 1'b0;
    end else begin
      sync_rx        <= go;
      rx_update_done <= (lag != 16'h0000) && (cnt == lag);
      tx_pdo_done    <= (lag != 16'h0000) && (cnt == lag + 16'h0001);
      cnt            <= go ? 16'h0001 : ((cnt == 16'hFFFF) ? cnt : cnt + 16'h0001);
    end
  end
endmodule : cosg_master_model
`default_nettype wire

// ---- testbench/tb_canopen_sync_guard_store.sv ----
// Self-checking bench for the communication-object core
`timescale 1ns/10ps
`default_nettype none
`include "cosg_regs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_canopen_sync_guard_store
  import cosg_pkg::*;
;
  typedef struct packed {
    logic w; logic [15:0] i; logic [7:0] s; logic [31:0] d; logic [3:0] r; logic c; logic [31:0] v;
  } cosg_row_type;
  logic        clk, nrst, go, guard_req, sdo_req, sdo_write, sdo_segment;
  logic        sync_rx, rx_update_done, tx_pdo_done, sdo_ack, sdo_abort, sdo_seg_last;
  logic        pdo_drop, emcy_tx, guard_expired, save_app_params, load_app_defaults;
  logic [1:0]  conn_loss_action, conn_loss_react;
  logic [3:0]  sdo_seg_len;
  logic [7:0]  sdo_subindex, guarding_multiplier;
  logic [15:0] lag, sdo_index, guarding_interval_ms;
  logic [31:0] sdo_wdata, sdo_rdata, sdo_abort_code, sync_window_length;
  logic [63:0] emcy_data;
  int          err_count, num_checks, cyc, emcy_n, emcy_at, sync_at, n;
  // Row result field is {ack, abort, save, load}
  cosg_row_type rows [18] = '{
    '{0, 16'h1010, 8'h00, 32'h0, 4'h8, 1, 32'h3},
    '{0, 16'h1011, 8'h00, 32'h0, 4'h8, 1, 32'h3},
    '{0, 16'h100C, 8'h00, 32'h0, 4'h8, 1, 32'h0},
    '{0, 16'h100D, 8'h00, 32'h0, 4'h8, 1, 32'h0},
    '{1, 16'h1010, 8'h03, 32'h65766173, 4'hA, 0, 32'h0},
    '{1, 16'h1010, 8'h03, 32'h65766174, 4'h4, 1, 32'h08000020},
    '{1, 16'h1011, 8'h03, 32'h64616F6C, 4'h9, 0, 32'h0},
    '{1, 16'h1011, 8'h03, 32'h65766173, 4'h4, 1, 32'h08000020},
    '{1, 16'h1011, 8'h01, 32'h64616F6C, 4'h8, 0, 32'h0},
    '{1, 16'h1010, 8'h02, 32'h65766173, 4'h8, 0, 32'h0},
    '{1, 16'h1009, 8'h00, 32'h1, 4'h4, 1, 32'h06010002},
    '{1, 16'h1010, 8'h00, 32'h3, 4'h4, 1, 32'h06010002},
    '{0, 16'h1011, 8'h04, 32'h0, 4'h4, 1, 32'h06020000},
    '{1, 16'h1007, 8'h00, 32'h3, 4'h8, 0, 32'h0},
    '{0, 16'h1007, 8'h00, 32'h0, 4'h8, 1, 32'h3},
    '{1, 16'h100C, 8'h00, 32'h1, 4'h8, 0, 32'h0},
    '{1, 16'h100D, 8'h00, 32'h2, 4'h8, 0, 32'h0},
    '{0, 16'h100D, 8'h00, 32'h0, 4'h8, 1, 32'h2}};
  cosg_core cosg_core_inst (.*);
  cosg_master_model cosg_master_model_inst (.*);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Event log; cycle stamps let the window length be judged in microseconds
  always @(posedge clk) begin
    cyc++;
    if (sync_rx) sync_at = cyc;
    if (emcy_tx) begin
      emcy_n++;
      emcy_at = cyc;
    end
  end
  // ------------
  // Tasks
  // ------------
  task automatic sdo(input logic w, s, input logic [15:0] i, input logic [7:0] sb, input logic [31:0] d);
    @(posedge clk);
    sdo_req <= 1'b1;
    sdo_write <= w;
    sdo_segment <= s;
    sdo_index <= i;
    sdo_subindex <= sb;
    sdo_wdata <= d;
    @(posedge clk);
    sdo_req <= 1'b0;
    #1;
  endtask : sdo
  // One SYNC period, then emergency count and drop level are checked
  task automatic win(input logic [15:0] l, input int exp_n, input logic exp_drop);
    int n0;
    n0 = emcy_n;
    @(posedge clk) go <= 1'b1;
    lag <= l;
    @(posedge clk) go <= 1'b0;
    repeat (200) @(posedge clk);
    #1;
    `CHK(emcy_n - n0, exp_n)
    `CHK(pdo_drop, exp_drop)
  endtask : win
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  // ------------
  // Main sequence
  // ------------
  initial begin
    {nrst, go, guard_req, sdo_req, sdo_write, sdo_segment} = '0;
    {lag, sdo_index, sdo_subindex, sdo_wdata, conn_loss_action} = '0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    #1;
    `CHK({pdo_drop, emcy_tx, guard_expired, sync_window_length}, 35'h0)
    `CHK({guarding_interval_ms, guarding_multiplier}, 24'h0)
    foreach (rows[k]) begin
      sdo(rows[k].w, 1'b0, rows[k].i, rows[k].s, rows[k].d);
      `CHK({sdo_ack, sdo_abort, save_app_params, load_app_defaults}, rows[k].r)
      if (rows[k].c) `CHK(sdo_abort ? sdo_abort_code : sdo_rdata, rows[k].v)
    end
    // Each string: length 8, then two segments of four visible characters
    for (int i = 0; i < 3; i++) begin
      sdo(1'b0, 1'b0, `COSG_IDX_DEV_NAME + 16'(i), 8'h00, 32'h0);
      `CHK(sdo_rdata, 32'h8)
      for (int k = 0; k < 2; k++) begin
        sdo(1'b0, 1'b1, `COSG_IDX_DEV_NAME + 16'(i), 8'h00, 32'h0);
        `CHK({sdo_seg_len, sdo_seg_last}, {4'h4, k[0]})
        for (int b = 0; b < 4; b++) `CHK(sdo_rdata[8*b+:8] inside {[8'h20:8'h7E]}, 1'b1)
      end
    end
    win(16'h0000, 1, 1'b1);
    `CHK((emcy_at - sync_at) inside {[80:125]}, 1'b1)
    `CHK(emcy_data, {`COSG_EMCY_INT_CODE, 24'h0, `COSG_EMCY_ERR_REG, `COSG_EMCY_SYNC_CODE})
    win(16'h0000, 0, 1'b1);
    win(16'h000A, 0, 1'b0);
    win(16'h0000, 1, 1'b1);
    sdo(1'b1, 1'b0, `COSG_IDX_SYNC_WINDOW, 8'h00, 32'h0);
    win(16'h0000, 0, 1'b0);
    // Guarding at 1 ms times 2: expiry lands in the second millisecond tick
    @(posedge clk) guard_req <= 1'b1;
    conn_loss_action <= COSG_REACT_STOP;
    @(posedge clk) guard_req <= 1'b0;
    n = 0;
    while (guard_expired !== 1'b1 && n < 90000) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(n inside {[40000:80005]}, 1'b1)
    `CHK(conn_loss_react, COSG_REACT_STOP)
    finish_test();
  end
endmodule : tb_canopen_sync_guard_store
`default_nettype wire
